// ==== src/crc_defines.vh ====
// Register map, field positions, reset values and bus encodings of the CRC unit
`ifndef CRC_DEFINES_VH
`define CRC_DEFINES_VH

// Register byte offsets
`define CRC_OFS_DATA        5'h00
`define CRC_OFS_SCRATCH     5'h04
`define CRC_OFS_CONTROL     5'h08
`define CRC_OFS_SEED        5'h10
`define CRC_OFS_COEFF       5'h14

// Reset values
`define CRC_SEED_RESET      32'hffffffff
`define CRC_COEFF_RESET     32'h04c11db7
`define CRC_SCRATCH_RESET   8'h00
`define CRC_CONTROL_RESET   5'h00

// Control register fields
`define CTRL_REINIT_BIT     0
`define CTRL_WSEL_MSB       4
`define CTRL_WSEL_LSB       3
`define CTRL_IN_MSB         6
`define CTRL_IN_LSB         5
`define CTRL_OUT_BIT        7
`define CTRL_STORE_MSB      7
`define CTRL_STORE_LSB      3

// Generator width selections
`define WSEL_32             2'h0
`define WSEL_16             2'h1
`define WSEL_8              2'h2
`define WSEL_7              2'h3

// Masks and top bit index per generator width
`define MASK_32             32'hffffffff
`define MASK_16             32'h0000ffff
`define MASK_8              32'h000000ff
`define MASK_7              32'h0000007f
`define TOP_32              5'h1f
`define TOP_16              5'h0f
`define TOP_8               5'h07
`define TOP_7               5'h06

// Input reflection modes
`define REFL_NONE           2'h0
`define REFL_BYTE           2'h1
`define REFL_HALF           2'h2
`define REFL_WORD           2'h3

// Bus transfer sizes and transfer type bit
`define HSIZE_BYTE          3'h0
`define HSIZE_HALF          3'h1
`define HSIZE_WORD          3'h2
`define HTRANS_ACTIVE_BIT   1

// Byte counts minus one per access width
`define BYTES_BYTE          2'h0
`define BYTES_HALF          2'h1
`define BYTES_WORD          2'h3

`endif

// ==== src/programmable_crc_unit.v ====
// Programmable CRC calculation unit with an AHB-Lite register slave
`timescale 1ns/1ps
`include "crc_defines.vh"
// Functional notes
// R1 - Data write folds in; read returns checksum
// R2 - Data port takes word, half, byte
// R3 - Process per access width, may vary
// R4 - Word four, half two, byte one cycle
// R5 - Input buffer accepts next write immediately
// R6 - Input reflection by byte, half, word
// R7 - Output reflection reverses checksum bit order
// R8 - Width select: 32, 16, 8, 7 bits
// R9 - Reinit bit loads seed, self clears
// R10 - Seed write also loads checksum
// R11 - Seed and checksum reset to ones
// R12 - Scratch byte survives reinitialise
// R13 - Narrow checksum sits in low bits
// R14 - Master puts narrow coefficients low
// R15 - Master programs only odd polynomials
// R16 - No polynomial change mid calculation
// R17 - Coefficients reset to Ethernet polynomial
// R18 - Master writes zeros to reserved bits
// R19 - Data read stalls until work done
// R20 - MSB-first serial division, implicit top term
module programmable_crc_unit
(
	input  wire        clock,      // Bus clock
	input  wire        srst,       // Synchronous reset, active high
	input  wire        hsel,       // Slave select
	input  wire [4:0]  haddr,      // Byte address within the unit
	input  wire [1:0]  htrans,     // Transfer type
	input  wire        hwrite,     // Write when high
	input  wire [2:0]  hsize,      // Transfer size
	input  wire [31:0] hwdata,     // Write data
	input  wire        hready,     // Bus-wide ready
	output wire        hreadyout,  // This slave's ready
	output wire        hresp,      // Always OKAY
	output wire [31:0] hrdata      // Read data
);

////////////////////////////////////////////////////////////////////////////////
// Helper functions

// Bit reversal within bytes, half-words or the word
function [31:0] reflect;
	input [31:0] v;
	input [1:0]  mode;
	integer      i;
	begin
		reflect = v;
		for (i = 0; i < 32; i = i + 1)
		begin
			case (mode)
				`REFL_BYTE: reflect[i] = v[(i / 8) * 8 + 7 - (i % 8)];
				`REFL_HALF: reflect[i] = v[(i / 16) * 16 + 15 - (i % 16)];
				`REFL_WORD: reflect[i] = v[31 - i];
				default:    reflect[i] = v[i];
			endcase
		end
	end
endfunction

// One byte of MSB-first division; top term of the polynomial is implicit
function [31:0] crc_byte;
	input [31:0] c;
	input [7:0]  d;
	input [31:0] p;
	input [31:0] m;
	input [4:0]  top;
	integer      k;
	reg          fb;
	reg [31:0]   r;
	begin
		r = c & m;
		for (k = 7; k >= 0; k = k - 1)
		begin
			fb = r[top] ^ d[k];
			r  = (r << 1) & m;
			if (fb)
				r = r ^ (p & m);
		end
		crc_byte = r;
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Registers

reg [31:0] crc_reg;        // Running checksum
reg [31:0] seed_reg;       // Seed value
reg [31:0] coeff_reg;      // Generator coefficients
reg [7:0]  scratch_reg;    // Scratch byte
reg [4:0]  ctrl_reg;       // Control bits 7:3
reg        dp_valid_reg;   // Data phase pending
reg        dp_write_reg;   // Pending phase is a write
reg [4:0]  dp_addr_reg;    // Pending address
reg [2:0]  dp_size_reg;    // Pending size
reg        rd_loaded_reg;  // Read data captured, finish next
reg [31:0] rdata_reg;      // Read data flops
reg        buf_valid_reg;  // Input buffer holds a write
reg [31:0] buf_data_reg;   // Buffered data, left aligned
reg [1:0]  buf_cnt_reg;    // Buffered bytes minus one
reg        eng_busy_reg;   // Engine working
reg [31:0] eng_data_reg;   // Engine data, next byte on top
reg [1:0]  eng_cnt_reg;    // Engine bytes left minus one

////////////////////////////////////////////////////////////////////////////////
// Derived control values

wire [1:0] wsel     = ctrl_reg[`CTRL_WSEL_MSB - `CTRL_STORE_LSB:`CTRL_WSEL_LSB - `CTRL_STORE_LSB];
wire [1:0] in_mode  = ctrl_reg[`CTRL_IN_MSB - `CTRL_STORE_LSB:`CTRL_IN_LSB - `CTRL_STORE_LSB];
wire       out_refl = ctrl_reg[`CTRL_OUT_BIT - `CTRL_STORE_LSB];
reg [31:0] width_mask;     // Mask of the selected width
reg [4:0]  width_top;      // Top bit of the selected width

// Width select decode
always @*
begin
	case (wsel) // R8
		`WSEL_16:
		begin
			width_mask = `MASK_16;
			width_top  = `TOP_16;
		end
		`WSEL_8:
		begin
			width_mask = `MASK_8;
			width_top  = `TOP_8;
		end
		`WSEL_7:
		begin
			width_mask = `MASK_7;
			width_top  = `TOP_7;
		end
		default:
		begin
			width_mask = `MASK_32;
			width_top  = `TOP_32;
		end
	endcase
end

// Checksum as seen by a read: masked low bits, optionally reversed
wire [31:0] crc_masked = crc_reg & width_mask; // R13
wire [31:0] crc_view   = out_refl ? (reflect(crc_masked, `REFL_WORD) >> (5'h1f - width_top))
                                  : crc_masked; // R7

////////////////////////////////////////////////////////////////////////////////
// Bus decode and handshake

wire addr_go   = hsel & htrans[`HTRANS_ACTIVE_BIT] & hready;
wire dp_data   = dp_addr_reg == `CRC_OFS_DATA;
wire dp_word   = dp_size_reg == `HSIZE_WORD;
wire eng_last  = eng_busy_reg & (eng_cnt_reg == 2'h0);
wire buf_take  = buf_valid_reg & (~eng_busy_reg | eng_last);
wire wr_stall  = dp_write_reg & dp_data & buf_valid_reg & ~buf_take; // R5
wire rd_idle   = ~eng_busy_reg & ~buf_valid_reg;
wire rd_stall  = ~dp_write_reg & ~rd_loaded_reg;

assign hreadyout = ~dp_valid_reg | ~(wr_stall | rd_stall);
assign hresp     = 1'b0;
assign hrdata    = rdata_reg;

wire wr_go     = dp_valid_reg & dp_write_reg & hreadyout;
wire size_ok   = dp_data ? (dp_size_reg <= `HSIZE_WORD) : dp_word; // R2
wire wr_data   = wr_go & dp_data & size_ok;
wire wr_seed   = wr_go & (dp_addr_reg == `CRC_OFS_SEED) & size_ok;
wire wr_ctrl   = wr_go & (dp_addr_reg == `CRC_OFS_CONTROL) & size_ok;
wire reinit    = wr_ctrl & hwdata[`CTRL_REINIT_BIT];
wire flush     = reinit | wr_seed;

////////////////////////////////////////////////////////////////////////////////
// Incoming data shaping

reg [1:0]  eff_mode;       // Reflection capped at access width
reg [1:0]  wr_cnt;         // Bytes of this write minus one
reg [31:0] wr_aligned;     // Reflected data moved to the top

// Reflect and left-align the written data
always @*
begin
	case (dp_size_reg) // R3
		`HSIZE_BYTE: wr_cnt = `BYTES_BYTE;
		`HSIZE_HALF: wr_cnt = `BYTES_HALF;
		default:     wr_cnt = `BYTES_WORD;
	endcase
	// Reflection never reaches past the written bytes
	if (in_mode > {1'b0, wr_cnt[0]} + 2'h1 && wr_cnt != `BYTES_WORD)
		eff_mode = {1'b0, wr_cnt[0]} + 2'h1;
	else
		eff_mode = in_mode; // R6
	wr_aligned = reflect(hwdata, eff_mode) << {~wr_cnt, 3'h0};
end

////////////////////////////////////////////////////////////////////////////////
// Bus address phase capture and read data

// Track the pending data phase and load read data
always @(posedge clock)
begin
	if (srst)
	begin
		dp_valid_reg  <= 1'b0;
		dp_write_reg  <= 1'b0;
		dp_addr_reg   <= 5'h00;
		dp_size_reg   <= 3'h0;
		rd_loaded_reg <= 1'b0;
		rdata_reg     <= 32'h00000000;
	end
	else
	begin
		if (hready)
		begin
			dp_valid_reg <= addr_go;
			dp_write_reg <= hwrite;
			dp_addr_reg  <= haddr;
			dp_size_reg  <= hsize;
		end
		// Capture read data in the first cycle the data port is idle, or at once for other registers
		if (dp_valid_reg & ~dp_write_reg & ~rd_loaded_reg & (rd_idle | ~dp_data)) // R19
		begin
			rd_loaded_reg <= 1'b1;
			case (dp_addr_reg)
				`CRC_OFS_DATA:    rdata_reg <= crc_view; // R1
				`CRC_OFS_SCRATCH: rdata_reg <= {24'h000000, scratch_reg};
				`CRC_OFS_CONTROL: rdata_reg <= {24'h000000, ctrl_reg, 3'h0};
				`CRC_OFS_SEED:    rdata_reg <= seed_reg;
				`CRC_OFS_COEFF:   rdata_reg <= coeff_reg;
				default:          rdata_reg <= 32'h00000000;
			endcase
		end
		else if (rd_loaded_reg)
			rd_loaded_reg <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Configuration registers

// Seed, coefficients, scratch and control writes
always @(posedge clock)
begin
	if (srst)
	begin
		seed_reg    <= `CRC_SEED_RESET; // R11
		coeff_reg   <= `CRC_COEFF_RESET; // R17
		scratch_reg <= `CRC_SCRATCH_RESET;
		ctrl_reg    <= `CRC_CONTROL_RESET;
	end
	else
	begin
		if (wr_seed)
			seed_reg <= hwdata;
		if (wr_go & (dp_addr_reg == `CRC_OFS_COEFF) & size_ok)
			coeff_reg <= hwdata;
		// Scratch byte is not touched by a reinitialise
		if (wr_go & (dp_addr_reg == `CRC_OFS_SCRATCH) & size_ok)
			scratch_reg <= hwdata[7:0]; // R12
		// Reinit bit is not stored, so it always reads back zero
		if (wr_ctrl)
			ctrl_reg <= hwdata[`CTRL_STORE_MSB:`CTRL_STORE_LSB]; // R9
	end
end

////////////////////////////////////////////////////////////////////////////////
// Input buffer

// One write waits here while the engine is busy
always @(posedge clock)
begin
	if (srst | flush)
	begin
		buf_valid_reg <= 1'b0;
		buf_data_reg  <= 32'h00000000;
		buf_cnt_reg   <= 2'h0;
	end
	else if (wr_data)
	begin
		buf_valid_reg <= 1'b1; // R5
		buf_data_reg  <= wr_aligned;
		buf_cnt_reg   <= wr_cnt;
	end
	else if (buf_take)
		buf_valid_reg <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// Calculation engine

// One byte per cycle, taken from the top of the engine data
always @(posedge clock)
begin
	if (srst)
	begin
		crc_reg      <= `CRC_SEED_RESET; // R11
		eng_busy_reg <= 1'b0;
		eng_data_reg <= 32'h00000000;
		eng_cnt_reg  <= 2'h0;
	end
	else if (flush)
	begin
		// Reinitialise or seed write restarts from the new seed
		crc_reg      <= wr_seed ? hwdata : seed_reg; // R9 R10
		eng_busy_reg <= 1'b0;
		eng_cnt_reg  <= 2'h0;
	end
	else
	begin
		if (eng_busy_reg)
			crc_reg <= crc_byte(crc_reg, eng_data_reg[31:24], coeff_reg,
				width_mask, width_top); // R1 R20
		if (buf_take)
		begin
			eng_busy_reg <= 1'b1;
			eng_data_reg <= buf_data_reg;
			eng_cnt_reg  <= buf_cnt_reg; // R4
		end
		else if (eng_busy_reg)
		begin
			eng_data_reg <= eng_data_reg << 8;
			eng_cnt_reg  <= eng_cnt_reg - 2'h1;
			if (eng_last)
				eng_busy_reg <= 1'b0; // R4
		end
	end
end

endmodule

// ==== dv/crc_unit_properties.sv ====
// Bus timing checker for the CRC unit ports
`timescale 1ns/1ps
module crc_unit_properties (
	input logic        clock,
	input logic        srst,
	input logic        hsel,
	input logic [4:0]  haddr,
	input logic [1:0]  htrans,
	input logic        hwrite,
	input logic [2:0]  hsize,
	input logic [31:0] hwdata,
	input logic        hready,
	input logic        hreadyout,
	input logic        hresp,
	input logic [31:0] hrdata
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	wire acc = hsel & htrans[1] & hready;       // Address phase taken
	wire dwr = acc & hwrite & (haddr == 5'h00);  // Data port write
	wire drd = acc & !hwrite & (haddr == 5'h00); // Data port read
	// Two quiet spans cover a stalled write, a full buffer and a busy engine
	sequence quiet_s; !dwr [*6]; endsequence
	sequence wword_s; dwr & (hsize == 3'h2); endsequence
	resp_okay_a: assert property (hresp == 1'b0)
		else $error("error response seen");
	reset_idle_a: assert property ($past(srst) |-> hreadyout && hrdata == 32'h0)
		else $error("bus not idle after reset");
	other_read_a: assert property (acc & !hwrite & (haddr != 5'h00) |=> !hreadyout ##1 hreadyout)
		else $error("register read wait wrong");
	reg_write_a: assert property (acc & hwrite & (haddr != 5'h00) |=> hreadyout)
		else $error("register write stalled");
	read_stall_a: assert property (drd |=> !hreadyout ##[1:12] hreadyout)
		else $error("checksum read wait wrong");
	hold_rdata_a: assert property (acc & hwrite |=> $stable(hrdata))
		else $error("read data moved on write");
	word_busy_a: assert property (quiet_s ##1 quiet_s ##1 wword_s ##1 drd |=> !hreadyout [*6] ##1 hreadyout)
		else $error("word step too short");
	buffer_free_a: assert property (quiet_s ##1 quiet_s ##1 dwr ##1 dwr |=> hreadyout)
		else $error("second write stalled");
endmodule
bind programmable_crc_unit crc_unit_properties chk (.clock(clock), .srst(srst), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

// ==== dv/crc_bus_master.sv ====
// Bus master model that drives the CRC unit registers
`timescale 1ns/1ps
module crc_bus_master (
	input  wire         clock,
	input  wire         hready,
	input  wire  [31:0] hrdata,
	output logic        hsel,
	output logic [4:0]  haddr,
	output logic [1:0]  htrans,
	output logic        hwrite,
	output logic [2:0]  hsize,
	output logic [31:0] hwdata
);
	logic [31:0] rdata; // Data of the last finished phase
	logic [31:0] pend;  // Write data owed to the next phase
	initial
	begin
		{hsel, haddr, htrans, hwrite, hsize} = '0;
		hwdata = '0;
		pend = '0;
	end
	// One address phase held until taken; the prior data phase rides along
	task automatic go(input t, input w, input [4:0] a, input [2:0] s, input [31:0] d);
	begin
		@(negedge clock);
		hsel = t;
		htrans = {t, 1'b0};
		hwrite = w;
		haddr = a;
		hsize = s;
		hwdata = pend;
		do @(posedge clock); while (!hready);
		rdata = hrdata;
		pend = w ? d : ~pend; // Released data lines toggle
	end
	endtask
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the CRC unit
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {logic [7:0] k; logic [31:0] p, sd, d; logic [2:0] s;} row_t;
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	wire         hsel, hwrite, hreadyout, hresp;
	wire  [4:0]  haddr;
	wire  [1:0]  htrans;
	wire  [2:0]  hsize;
	wire  [31:0] hwdata, hrdata;
	wire         hready = hreadyout; // Single slave on the bus
	int          failures = 0;
	int          total_checks = 0;
	int          cycles = 0;
	int          i;
	logic [31:0] v, e;
	// Control, coefficients, seed, data, size
	row_t rows [9] = '{'{8'h00, 32'h04c11db7, 32'hffffffff, 32'h1a2b3c4d, 3'h2},
		'{8'h28, 32'h00001021, 32'h0000ffff, 32'h0000a5c3, 3'h1},
		'{8'h50, 32'h00000007, 32'h000000ff, 32'h1a2b3c4d, 3'h2},
		'{8'hf8, 32'h00000009, 32'h0000007f, 32'h0000005a, 3'h0},
		'{8'he0, 32'h04c11db7, 32'hffffffff, 32'h11223344, 3'h2},
		'{8'h80, 32'h04c11db7, 32'h12345678, 32'h0000beef, 3'h1},
		'{8'h60, 32'h04c11db7, 32'hffffffff, 32'h000000a5, 3'h0},
		'{8'h60, 32'h04c11db7, 32'hffffffff, 32'h00005a17, 3'h1},
		'{8'h18, 32'h00000045, 32'h0000007f, 32'hdeadbeef, 3'h2}};
	logic [4:0]  rst_adr [6] = '{5'h00, 5'h04, 5'h08, 5'h10, 5'h14, 5'h0c};
	logic [31:0] rst_val [6] = '{32'hffffffff, 32'h0, 32'h0, 32'hffffffff, 32'h04c11db7, 32'h0};
	programmable_crc_unit dut (.clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
	crc_bus_master m (.clock(clock), .hready(hready), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	always #10 clock = ~clock;
	////////////////////////////////////////////////////////////////////////////////
	// Hang guard
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			give_verdict();
		end
	end
	function automatic int wid(input [1:0] z);
		wid = z == 2'h0 ? 32 : z == 2'h1 ? 16 : z == 2'h2 ? 8 : 7;
	endfunction
	// Reference step: reflect input, fold bits MSB first
	function automatic [31:0] step(input [31:0] c, d, input [2:0] s, input [7:0] k, input [31:0] p);
		int j, g, w;
		logic [31:0] r, mk;
		logic fb;
		begin
			w = wid(k[4:3]);
			mk = w == 32 ? 32'hffffffff : (32'h1 << w) - 32'h1;
			g = k[6:5] == 2'h0 ? 1 : 8 << ((k[6:5] - 1) > s ? s : k[6:5] - 1);
			for (j = 0; j < (8 << s); j++) r[j - j % g + g - 1 - j % g] = d[j];
			c = c & mk;
			for (j = (8 << s) - 1; j >= 0; j--)
			begin
				fb = c[w - 1] ^ r[j];
				c = (c << 1) & mk;
				if (fb) c = c ^ (p & mk);
			end
			step = c;
		end
	endfunction
	function automatic [31:0] outr(input [31:0] c, input [7:0] k);
		int j;
		begin
			outr = c;
			if (k[7]) for (j = 0; j < wid(k[4:3]); j++) outr[j] = c[wid(k[4:3]) - 1 - j];
		end
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	task automatic wr(input [4:0] a, input [2:0] s, input [31:0] d);
		m.go(1'b1, 1'b1, a, s, d);
	endtask
	task automatic rd(input [4:0] a, output [31:0] x);
	begin
		m.go(1'b1, 1'b0, a, 3'h2, 32'h0);
		m.go(1'b0, 1'b0, 5'h00, 3'h2, 32'h0);
		x = m.rdata;
	end
	endtask
	task automatic chk(input [31:0] seen, exp);
	begin
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	end
	endtask
	task automatic give_verdict;
	begin
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (4) @(posedge clock);
		@(negedge clock) srst = 1'b0;
		for (i = 0; i < 6; i++)
		begin
			rd(rst_adr[i], v);
			chk(v, rst_val[i]);
		end
		foreach (rows[n])
		begin
			wr(5'h08, 3'h2, {24'h0, rows[n].k});
			wr(5'h14, 3'h2, rows[n].p);
			wr(5'h10, 3'h2, rows[n].sd);
			wr(5'h00, rows[n].s, rows[n].d);
			rd(5'h00, v);
			e = step(rows[n].sd, rows[n].d, rows[n].s, rows[n].k, rows[n].p);
			chk(v, outr(e, rows[n].k));
		end
		// Reinitialise while a word waits in the buffer; scratch survives and refuses a byte write
		wr(5'h08, 3'h2, 32'h0);
		wr(5'h04, 3'h2, 32'ha5);
		wr(5'h04, 3'h0, 32'hff);
		wr(5'h00, 3'h2, 32'h1234);
		wr(5'h08, 3'h2, 32'h1);
		rd(5'h00, v);
		chk(v, 32'h7f);
		rd(5'h04, v);
		chk(v, 32'ha5);
		rd(5'h08, v);
		chk(v, 32'h0);
		wr(5'h0c, 3'h2, 32'hffffffff);
		rd(5'h0c, v);
		chk(v, 32'h0);
		// Back-to-back writes of mixed widths, read at once
		wr(5'h14, 3'h2, 32'h04c11db7);
		wr(5'h10, 3'h2, 32'hffffffff);
		wr(5'h00, 3'h0, 32'h9c);
		wr(5'h00, 3'h1, 32'h5a17);
		wr(5'h00, 3'h2, 32'h1a2b3c4d);
		rd(5'h00, v);
		e = step(32'hffffffff, 32'h9c, 3'h0, 8'h00, 32'h04c11db7);
		e = step(e, 32'h5a17, 3'h1, 8'h00, 32'h04c11db7);
		chk(v, step(e, 32'h1a2b3c4d, 3'h2, 8'h00, 32'h04c11db7));
		give_verdict();
	end
endmodule
